/* File: verilog/board_glue_pkg.sv */
// Summary of operation
// - Crystal mode cuts the oscillator from the reference clock, held at 0.
// - One option switch sets the clock-mode straps and the filter capacitor.
// - Straps drive 11 for oscillator, 10 for crystal mode, in power-on reset.
// - Transceivers open only for enabled board regions or hard-reset config.
// - A disabled region never opens the transceivers.
// - Each local memory, status registers too, can be disabled separately.
// - Removed control/status registers stay unreachable until power cycles.
// - Select 0 flash, 1 control registers, 2 and 3 DRAM; user selects 4 to 7 are never enabled.
// - DRAM size and delay are reported in the status register for software.
// - An active-low control bit enables or disables the DRAM while the control registers have not been removed.
// - In 16-bit DRAM mode the upper data half of the DRAM is used only when hard-reset config opens it.
// - Half-word mode switches two DRAM address inputs to other address bits.
package board_glue_pkg;
  localparam int NUM_CS         = 8;
  localparam int CS_FLASH       = 0;
  localparam int CS_REGS        = 1;
  localparam int CS_DRAM1       = 2;
  localparam int CS_DRAM2       = 3;
  // control register bit positions
  localparam int CTL_WIDTH      = 8;
  localparam int CTL_FLASH_EN_N = 0;
  localparam int CTL_REGS_EN_N  = 1;
  localparam int CTL_DRAM_EN_N  = 2;
  localparam int CTL_HALF_N     = 3;
  localparam int CTL_FLASH_CFG  = 4;
  // flash, registers and DRAM enabled, full word width
  localparam logic [7:0] CTL_RESET = 8'h08;
  // status register layout
  localparam int STS_WIDTH      = 8;
  localparam int STS_SIZE_LSB   = 0;
  localparam int STS_SIZE_W     = 3;
  localparam int STS_DELAY_BIT  = 3;
  localparam int STS_HALF_BIT   = 4;
  localparam int STS_REGS_BIT   = 5;
  localparam int STS_XTAL_BIT   = 6;
  localparam logic [1:0] STRAP_OSC  = 2'h3;
  localparam logic [1:0] STRAP_XTAL = 2'h2;
  localparam logic [7:0] STS_RESET    = 8'h00;
  localparam logic [7:0] REGION_RESET = 8'h00;
  // dram address switch
  localparam int         MUX_WIDTH    = 2;
  localparam logic [1:0] MUX_RESET    = 2'h0;
  // pin filters
  localparam int         SYNC_STAGES  = 3;
  localparam int         PIN_COUNT    = 4;
  localparam int         PIN_MODE     = 0;
  localparam int         PIN_POR      = 1;
  localparam int         PIN_HRST     = 2;
  localparam int         PIN_OSC      = 3;
  localparam logic [3:0] PIN_RESET    = 4'h0;
endpackage

/* File: verilog/board_memory_select_glue.sv */
`timescale 1ns/10ps
module board_memory_select_glue #(
  parameter int CS_COUNT   = board_glue_pkg::NUM_CS,
  parameter int CTL_W      = board_glue_pkg::CTL_WIDTH,
  parameter int STS_W      = board_glue_pkg::STS_WIDTH,
  parameter int SIZE_W     = board_glue_pkg::STS_SIZE_W,
  parameter int MUX_W      = board_glue_pkg::MUX_WIDTH,
  parameter int SYNC_DEPTH = board_glue_pkg::SYNC_STAGES
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                poweronReset_n,
  input  wire logic                hardReset_n,
  input  wire logic                clockModeSwitch,
  input  wire logic                oscClockIn,
  input  wire logic [CS_COUNT-1:0] chipSelect_n,
  input  wire logic                ctrlWrite,
  input  wire logic [CTL_W-1:0]    ctrlWriteData,
  input  wire logic [SIZE_W-1:0]   dramSizeCode,
  input  wire logic                dramDelay70,
  input  wire logic [MUX_W-1:0]    cpuAddrFull,
  input  wire logic [MUX_W-1:0]    cpuAddrHalf,
  output logic                     refClockInput,
  output logic      [1:0]          clockModeStraps,
  output logic                     strapsOe,
  output logic                     bigFilterCapOn,
  output logic                     xcvrEnable,
  output logic                     xcvrUpperEnable,
  output logic      [CS_COUNT-1:0] regionSelect,
  output logic      [MUX_W-1:0]    dramAddrMux,
  output logic      [CTL_W-1:0]    boardControl,
  output logic      [STS_W-1:0]    boardStatus
);
  localparam int PINS = board_glue_pkg::PIN_COUNT;

  // filtered pin levels
  wire  logic [PINS-1:0]     pinRaw;
  wire  logic [PINS-1:0]     pinLevel_next;
  logic       [PINS-1:0]     pinLevel_reg;
  logic                      xtalMode;
  logic                      porActive;
  logic                      hrActive;
  logic                      oscLevel;

  // control register and removal flag
  logic       [CTL_W-1:0]    ctrl_reg;
  logic       [CTL_W-1:0]    ctrl_next;
  logic                      regsGone_reg;
  logic                      regsGone_next;
  logic                      regsAccess;
  logic                      ctrlTaken;
  logic                      regsRemoveReq;

  // select decode
  logic       [CS_COUNT-1:0] csOn;
  wire  logic [CS_COUNT-1:0] csEnabled;
  logic       [CS_COUNT-1:0] regionHit;
  logic                      flashOn;
  logic                      dramOn;
  logic                      halfWord;
  logic                      dramAccess;
  logic                      validAccess;
  logic                      hrConfig;
  logic                      upperBlocked;

  // output registers
  logic                      refClock_reg;
  logic                      refClock_next;
  logic       [1:0]          straps_reg;
  logic       [1:0]          straps_next;
  logic                      strapsOe_reg;
  logic                      strapsOe_next;
  logic                      filterCap_reg;
  logic                      filterCap_next;
  logic                      xcvr_reg;
  logic                      xcvr_next;
  logic                      xcvrUpper_reg;
  logic                      xcvrUpper_next;
  logic       [CS_COUNT-1:0] region_reg;
  logic       [CS_COUNT-1:0] region_next;
  logic       [MUX_W-1:0]    addrMux_reg;
  logic       [MUX_W-1:0]    addrMux_next;
  logic       [CTL_W-1:0]    ctrlCopy_reg;
  logic       [CTL_W-1:0]    ctrlCopy_next;
  logic       [STS_W-1:0]    status_reg;
  logic       [STS_W-1:0]    status_next;

  assign pinRaw[board_glue_pkg::PIN_MODE] = clockModeSwitch;
  assign pinRaw[board_glue_pkg::PIN_POR]  = poweronReset_n;
  assign pinRaw[board_glue_pkg::PIN_HRST] = hardReset_n;
  assign pinRaw[board_glue_pkg::PIN_OSC]  = oscClockIn;

  // each of the four pins, taken once the last two stages agree
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    logic [SYNC_DEPTH-1:0] chain_reg;
    logic                  agree;

    always_ff @(posedge core_clk) begin
      chain_reg <= {chain_reg[SYNC_DEPTH-2:0], pinRaw[p]};
    end

    assign agree = chain_reg[SYNC_DEPTH-1] == chain_reg[SYNC_DEPTH-2];
    assign pinLevel_next[p] = agree ? chain_reg[SYNC_DEPTH-2]
                                    : pinLevel_reg[p];
  end

  // resets read as active until the filter shows otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinLevel_reg <= board_glue_pkg::PIN_RESET;
    end else begin
      pinLevel_reg <= pinLevel_next;
    end
  end

  assign xtalMode  = pinLevel_reg[board_glue_pkg::PIN_MODE];
  assign porActive = ~pinLevel_reg[board_glue_pkg::PIN_POR];
  assign hrActive  = ~pinLevel_reg[board_glue_pkg::PIN_HRST];
  assign oscLevel  = pinLevel_reg[board_glue_pkg::PIN_OSC];

  assign csOn       = ~chipSelect_n;
  assign regsAccess = csOn[board_glue_pkg::CS_REGS] && !regsGone_reg;
  assign ctrlTaken  = ctrlWrite && regsAccess;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (porActive) begin
      ctrl_next = board_glue_pkg::CTL_RESET;
    end else if (ctrlTaken) begin
      ctrl_next = ctrlWriteData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= board_glue_pkg::CTL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign regsRemoveReq = ctrl_reg[board_glue_pkg::CTL_REGS_EN_N];
  assign regsGone_next = porActive ? 1'b0 : (regsGone_reg | regsRemoveReq);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regsGone_reg <= 1'b0;
    end else begin
      regsGone_reg <= regsGone_next;
    end
  end

  assign flashOn  = ~ctrl_reg[board_glue_pkg::CTL_FLASH_EN_N];
  assign dramOn   = ~ctrl_reg[board_glue_pkg::CTL_DRAM_EN_N];
  assign halfWord = ~ctrl_reg[board_glue_pkg::CTL_HALF_N];

  for (genvar c = 0; c < CS_COUNT; c++) begin : g_cs
    if (c == board_glue_pkg::CS_FLASH) begin : g_flash
      assign csEnabled[c] = flashOn;
    end else if (c == board_glue_pkg::CS_REGS) begin : g_regs
      assign csEnabled[c] = ~regsGone_reg;
    end else if ((c == board_glue_pkg::CS_DRAM1) ||
                 (c == board_glue_pkg::CS_DRAM2)) begin : g_dram
      assign csEnabled[c] = dramOn;
    end else begin : g_user
      assign csEnabled[c] = 1'b0;
    end
  end

  assign regionHit   = csOn & csEnabled;
  assign validAccess = |regionHit;
  assign hrConfig    = hrActive && ctrl_reg[board_glue_pkg::CTL_FLASH_CFG];
  assign dramAccess  = csOn[board_glue_pkg::CS_DRAM1] ||
                       csOn[board_glue_pkg::CS_DRAM2];

  // upper half idle for DRAM selects in half-word mode
  assign upperBlocked = halfWord && dramAccess;

  assign refClock_next = xtalMode ? 1'b0 : oscLevel;

  assign straps_next = xtalMode ? board_glue_pkg::STRAP_XTAL
                                : board_glue_pkg::STRAP_OSC;
  // held on through hard reset as well
  assign strapsOe_next  = porActive || hrActive;
  assign filterCap_next = xtalMode;

  assign xcvr_next      = validAccess || hrConfig;
  assign xcvrUpper_next = (validAccess && !upperBlocked) || hrConfig;
  assign region_next    = regionHit;

  assign addrMux_next  = halfWord ? cpuAddrHalf : cpuAddrFull;
  assign ctrlCopy_next = ctrl_reg;

  always_comb begin
    status_next = board_glue_pkg::STS_RESET;
    status_next[board_glue_pkg::STS_SIZE_LSB +: SIZE_W] = dramSizeCode;
    status_next[board_glue_pkg::STS_DELAY_BIT] = dramDelay70;
    status_next[board_glue_pkg::STS_HALF_BIT]  = halfWord;
    status_next[board_glue_pkg::STS_REGS_BIT]  = regsGone_reg;
    status_next[board_glue_pkg::STS_XTAL_BIT]  = xtalMode;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      refClock_reg <= 1'b0;
    end else begin
      refClock_reg <= refClock_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      straps_reg <= board_glue_pkg::STRAP_OSC;
    end else begin
      straps_reg <= straps_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strapsOe_reg <= 1'b0;
    end else begin
      strapsOe_reg <= strapsOe_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      filterCap_reg <= 1'b0;
    end else begin
      filterCap_reg <= filterCap_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      xcvr_reg <= 1'b0;
    end else begin
      xcvr_reg <= xcvr_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      xcvrUpper_reg <= 1'b0;
    end else begin
      xcvrUpper_reg <= xcvrUpper_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      region_reg <= board_glue_pkg::REGION_RESET;
    end else begin
      region_reg <= region_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addrMux_reg <= board_glue_pkg::MUX_RESET;
    end else begin
      addrMux_reg <= addrMux_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrlCopy_reg <= board_glue_pkg::CTL_RESET;
    end else begin
      ctrlCopy_reg <= ctrlCopy_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_reg <= board_glue_pkg::STS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  assign refClockInput   = refClock_reg;
  assign clockModeStraps = straps_reg;
  assign strapsOe        = strapsOe_reg;
  assign bigFilterCapOn  = filterCap_reg;
  assign xcvrEnable      = xcvr_reg;
  assign xcvrUpperEnable = xcvrUpper_reg;
  assign regionSelect    = region_reg;
  assign dramAddrMux     = addrMux_reg;
  assign boardControl    = ctrlCopy_reg;
  assign boardStatus     = status_reg;

endmodule

/* File: test/board_glue_assertions.sv */
`timescale 1ns/10ps
module board_glue_assertions (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [7:0] chipSelect_n,
  input wire logic       refClockInput,
  input wire logic [1:0] clockModeStraps,
  input wire logic       strapsOe,
  input wire logic       bigFilterCapOn,
  input wire logic       xcvrEnable,
  input wire logic [7:0] regionSelect,
  input wire logic [7:0] boardControl,
  input wire logic [7:0] boardStatus
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_xtal_ref_low: assert property (bigFilterCapOn |-> !refClockInput)
    else $error("ref clock not low");
  a_strap_xtal: assert property (strapsOe && bigFilterCapOn |->
    clockModeStraps == 2'h2) else $error("xtal straps");
  a_strap_osc: assert property (strapsOe && !bigFilterCapOn |->
    clockModeStraps == 2'h3) else $error("osc straps");
  a_region_cause: assert property (
    (regionSelect & $past(chipSelect_n)) == 8'h00) else $error("region");
  a_dram_gate: assert property ((|regionSelect[3:2]) |->
    !boardControl[2]) else $error("dram gate");
  a_xcvr_cause: assert property (xcvrEnable |->
    (|regionSelect) || strapsOe) else $error("xcvr open");
  a_regs_stay: assert property (boardStatus[5] && !strapsOe |=>
    boardStatus[5]) else $error("regs back");
  a_regs_closed: assert property (boardStatus[5] |->
    !regionSelect[1]) else $error("regs open");
endmodule
bind board_memory_select_glue board_glue_assertions board_glue_assertions_inst (
  .core_clk, .rst_n, .chipSelect_n, .refClockInput, .clockModeStraps,
  .strapsOe, .bigFilterCapOn, .xcvrEnable, .regionSelect, .boardControl,
  .boardStatus);

/* File: test/cpu_bus_model.sv */
`timescale 1ns/10ps
module cpu_bus_model (
  input  wire logic       core_clk,
  input  wire logic [2:0] selIdx,
  input  wire logic       selOn,
  output logic [7:0]      chipSelect_n,
  output logic            oscClockIn
);
  logic [2:0] oscDiv = 3'h0;
  // one select low, 2 and 3 carry the dram strobes
  assign chipSelect_n = selOn ? ~(8'h01 << selIdx) : 8'hff;
  // slow enough for the pin filter to follow
  always @(negedge core_clk) oscDiv <= oscDiv + 3'h1;
  assign oscClockIn = oscDiv[2];
endmodule

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic core_clk = 0, rst_n = 0, poweronReset_n = 0, hardReset_n = 1;
  logic clockModeSwitch = 0, ctrlWrite = 0, selOn = 0, osc, refClk;
  logic [2:0] selIdx = 0;
  logic [7:0] wdata = 0, cs_n, region, ctl, sts;
  logic oe, cap, xcvr, up;
  logic [1:0] straps, mux;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  initial forever #2.5 core_clk = ~core_clk;
  cpu_bus_model cpu_bus_model_inst (.core_clk, .selIdx, .selOn,
    .chipSelect_n(cs_n), .oscClockIn(osc));
  board_memory_select_glue board_memory_select_glue_inst (.core_clk, .rst_n,
    .poweronReset_n, .hardReset_n, .clockModeSwitch, .oscClockIn(osc),
    .chipSelect_n(cs_n), .ctrlWrite, .ctrlWriteData(wdata),
    .dramSizeCode(3'h5), .dramDelay70(1'b1), .cpuAddrFull(2'h1),
    .cpuAddrHalf(2'h2), .refClockInput(refClk), .clockModeStraps(straps),
    .strapsOe(oe), .bigFilterCapOn(cap), .xcvrEnable(xcvr),
    .xcvrUpperEnable(up), .regionSelect(region), .dramAddrMux(mux),
    .boardControl(ctl), .boardStatus(sts));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge core_clk);
    {selIdx, selOn, ctrlWrite, wdata} = {3'h1, 2'b11, d};
    @(negedge core_clk);
    {selOn, ctrlWrite} = 2'b00;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic sel(input logic [2:0] i);
    @(negedge core_clk);
    {selIdx, selOn} = {i, 1'b1};
    repeat (2) @(negedge core_clk);
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1;
    repeat (2) @(negedge core_clk);
    chk({oe, cap, 4'h0, straps}, 8'h83);
    poweronReset_n = 1;
    repeat (8) @(negedge core_clk);
    chk(sts & 8'h0f, 8'h0d);
    $display("reset test done");
    wr(8'h08);
    chk(ctl, 8'h08);
    sel(3'h2);
    chk({region, 7'h0, xcvr}, {8'h04, 8'h01});
    chk({6'h0, mux}, 8'h01);
    wr(8'h0c);
    sel(3'h2);
    chk({6'h0, region[2], xcvr}, 8'h00);
    sel(3'h5);
    chk({region, 7'h0, xcvr}, 16'h0000);
    $display("select test done");
    clockModeSwitch = 1;
    repeat (8) @(negedge core_clk);
    repeat (4) @(negedge core_clk) chk({6'h0, refClk, cap}, 8'h01);
    $display("clock test done");
    wr(8'h18);
    hardReset_n = 0;
    repeat (6) @(negedge core_clk);
    chk({3'h0, oe, xcvr, up, straps}, 8'h1e);
    hardReset_n = 1;
    repeat (6) @(negedge core_clk);
    chk({3'h0, oe, xcvr, up, straps}, 8'h02);
    $display("hard reset test done");
    wr(8'h00);
    sel(3'h2);
    chk({region, 2'h0, mux, 2'h0, up, xcvr}, 16'h0421);
    sel(3'h3);
    chk({region, 6'h0, up, xcvr}, 16'h0801);
    sel(3'h0);
    chk({region, 6'h0, up, xcvr}, 16'h0103);
    chk(sts & 8'h10, 8'h10);
    $display("half word test done");
    wr(8'h0a);
    wr(8'h08);
    chk(ctl, 8'h0a);
    sel(3'h1);
    chk({region[1], xcvr}, 2'b00);
    $display("lock test done");
    poweronReset_n = 0;
    repeat (8) @(negedge core_clk);
    chk({oe, 7'h0}, 8'h80);
    poweronReset_n = 1;
    repeat (8) @(negedge core_clk);
    chk(ctl, 8'h08);
    wr(8'h0c);
    chk(ctl, 8'h0c);
    $display("power cycle test done");
    end_of_test();
  end
endmodule
